// ### pio_pkg.sv
// constants for the parallel i/o block: register map, reset values, pin masks
// assumes pins are flattened as port*8+bit, port a = 0 through port g = 6
package pio_pkg;

  // port geometry
  localparam int NUM_PORTS = 7;
  localparam int PORT_W    = 8;
  localparam int FLAT_W    = NUM_PORTS * PORT_W;
  localparam int PIN_TOTAL = 54;
  localparam int ADDR_W    = 6;

  // register index inside one port's block of eight (address = port*8 + index)
  localparam logic [2:0] REG_DATA  = 3'h0;
  localparam logic [2:0] REG_DIR   = 3'h1;
  localparam logic [2:0] REG_PULL  = 3'h2;
  localparam logic [2:0] REG_SLEW  = 3'h3;
  localparam logic [2:0] REG_DRIVE = 3'h4;
  localparam logic [2:0] REG_PINS  = 3'h5;

  // port index of port a, whose slew/drive registers are port_a_slew_enable/_drive_select
  localparam logic [2:0] PORT_A = 3'h0;

  // reset values
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [7:0] DIR_RESET   = 8'h00;
  localparam logic [7:0] PULL_RESET  = 8'h00;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam logic [7:0] SLEW_RESET  = 8'hFF;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // bonded pins per port: c and g have seven
  localparam logic [7:0] FULL_PORT  = 8'hFF;
  localparam logic [7:0] SEVEN_PORT = 8'h7F;
  localparam logic [7:0] NO_PINS    = 8'h00;

  // port e sharing: serial peripheral on 7:4, timer channels on 3:2, async serial on 1:0
  localparam logic [7:0] E_SPI_BITS    = 8'hF0;
  localparam logic [7:0] E_TIMER_BITS  = 8'h0C;
  localparam logic [7:0] E_SERIAL_BITS = 8'h03;

  // masks, port g in the top byte down to port a in the bottom byte
  localparam logic [FLAT_W-1:0] PIN_MASK = {SEVEN_PORT, FULL_PORT, FULL_PORT, FULL_PORT,
                                            SEVEN_PORT, FULL_PORT, FULL_PORT};
  localparam logic [FLAT_W-1:0] ADC_MASK = {NO_PINS, NO_PINS, NO_PINS, FULL_PORT,
                                            NO_PINS, FULL_PORT, NO_PINS};
  localparam logic [FLAT_W-1:0] DIG_MASK = {SEVEN_PORT, FULL_PORT,
                                            E_SPI_BITS | E_TIMER_BITS | E_SERIAL_BITS,
                                            FULL_PORT, SEVEN_PORT, NO_PINS, NO_PINS};

endpackage

// ### pio_ports.sv
// parallel i/o ports: seven ports of pin data, direction and pin control
// assumes pad inputs are synchronous to mclk and peripherals drive claims directly
`timescale 1ns/1ps

module pio_ports
  import pio_pkg::*;
#(
  parameter logic [7:0] SLEW_RST = SLEW_RESET
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [7:0]        rdata,
  input  wire logic [FLAT_W-1:0] pad_in,
  output logic      [FLAT_W-1:0] pad_out,
  output logic      [FLAT_W-1:0] pad_oe_n,
  output logic      [FLAT_W-1:0] pad_pullup,
  output logic      [FLAT_W-1:0] pad_slew,
  output logic      [FLAT_W-1:0] pad_drive_hi,
  output logic      [FLAT_W-1:0] analog_sel,
  input  wire logic [FLAT_W-1:0] adc_claim,
  input  wire logic [FLAT_W-1:0] dig_claim,
  input  wire logic [FLAT_W-1:0] dig_oe,
  input  wire logic [FLAT_W-1:0] dig_out
);

  // flattened register bits, pin p of port k at k*8+p
  logic [FLAT_W-1:0] data_r;
  logic [FLAT_W-1:0] dir_r;
  logic [FLAT_W-1:0] pull_r;
  logic [FLAT_W-1:0] slew_r;
  logic [FLAT_W-1:0] drive_r;

  logic [FLAT_W-1:0] adc_own;
  logic [FLAT_W-1:0] dig_own;
  logic [FLAT_W-1:0] drive_en_nxt;
  logic [FLAT_W-1:0] level_nxt;
  logic [7:0]        rdata_nxt;
  logic [2:0]        port_sel;
  logic [2:0]        reg_sel;
  logic              port_ok;

  assign port_sel = addr[5:3];
  assign reg_sel  = addr[2:0];
  assign port_ok  = (port_sel < 3'(NUM_PORTS));

  // one port's byte out of a flattened vector
  function automatic logic [7:0] lane_get(input logic [FLAT_W-1:0] v, input logic [2:0] k);
    lane_get = v[k*PORT_W +: PORT_W];
  endfunction

  // replace one port's byte, keeping missing pins at zero
  function automatic logic [FLAT_W-1:0] lane_put(input logic [FLAT_W-1:0] v,
                                                 input logic [2:0] k,
                                                 input logic [7:0] d);
    logic [FLAT_W-1:0] r;
    r = v;
    r[k*PORT_W +: PORT_W] = d;
    lane_put = r & PIN_MASK;
  endfunction

  // write hit on a given register of the selected port
  function automatic logic hit(input logic [2:0] idx);
    hit = wr_stb && port_ok && (reg_sel == idx);
  endfunction

  // data registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_r <= {NUM_PORTS{DATA_RESET}};
    end else if (hit(REG_DATA)) begin
      data_r <= lane_put(data_r, port_sel, wdata);
    end
  end

  // direction registers, all inputs after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      dir_r <= {NUM_PORTS{DIR_RESET}};
    end else if (hit(REG_DIR)) begin
      dir_r <= lane_put(dir_r, port_sel, wdata);
    end
  end

  // pullup enables, off after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      pull_r <= {NUM_PORTS{PULL_RESET}} & PIN_MASK;
    end else if (hit(REG_PULL)) begin
      pull_r <= lane_put(pull_r, port_sel, wdata);
    end
  end

  // slew enables, limiting on after reset; port a byte is port_a_slew_enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      slew_r <= {NUM_PORTS{SLEW_RST}} & PIN_MASK;
    end else if (hit(REG_SLEW)) begin
      slew_r <= lane_put(slew_r, port_sel, wdata);
    end
  end

  // drive select, low drive after reset; port a byte is port_a_drive_select
  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_r <= {NUM_PORTS{DRIVE_RESET}} & PIN_MASK;
    end else if (hit(REG_DRIVE)) begin
      drive_r <= lane_put(drive_r, port_sel, wdata);
    end
  end

  // ownership: converter first, then a digital peripheral, then the port
  assign adc_own = adc_claim & ADC_MASK;
  assign dig_own = dig_claim & DIG_MASK & ~adc_own;

  // direction and level each pin should see next
  always_comb begin
    for (int i = 0; i < FLAT_W; i++) begin
      if (adc_own[i]) begin
        drive_en_nxt[i] = 1'b0;
      end else if (dig_own[i]) begin
        drive_en_nxt[i] = dig_oe[i];
      end else begin
        drive_en_nxt[i] = dir_r[i];
      end
      if (dig_own[i] && dig_oe[i]) begin
        level_nxt[i] = dig_out[i];
      end else begin
        level_nxt[i] = data_r[i];
      end
    end
    drive_en_nxt = drive_en_nxt & PIN_MASK;
    level_nxt    = level_nxt & drive_en_nxt;
  end

  // pad drive and pin control outputs, all registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      pad_out      <= '0;
      pad_oe_n     <= '1;
      pad_pullup   <= '0;
      pad_slew     <= '0;
      pad_drive_hi <= '0;
      analog_sel   <= '0;
    end else begin
      pad_out      <= level_nxt;
      pad_oe_n     <= ~drive_en_nxt;
      pad_pullup   <= pull_r & ~drive_en_nxt & ~adc_own;
      pad_slew     <= slew_r & drive_en_nxt;
      pad_drive_hi <= drive_r & drive_en_nxt;
      analog_sel   <= adc_own;
    end
  end

  // read mux: data reads return pin level for inputs, latch for outputs
  always_comb begin
    rdata_nxt = READ_ZERO;
    if (rd_stb && port_ok) begin
      case (reg_sel)
        REG_DATA: begin
          rdata_nxt = (lane_get(data_r, port_sel) & lane_get(dir_r, port_sel))
                    | (lane_get(pad_in & PIN_MASK, port_sel)
                       & ~lane_get(dir_r, port_sel));
        end
        REG_DIR:   rdata_nxt = lane_get(dir_r, port_sel);
        REG_PULL:  rdata_nxt = lane_get(pull_r, port_sel);
        REG_SLEW:  rdata_nxt = lane_get(slew_r, port_sel);
        REG_DRIVE: rdata_nxt = lane_get(drive_r, port_sel);
        REG_PINS:  rdata_nxt = lane_get(pad_in & PIN_MASK, port_sel);
        default:   rdata_nxt = READ_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= READ_ZERO;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_reset_inputs: assert property ($fell(rst) |-> pad_oe_n == '1)
    else $error("pins not all inputs after reset");
  a_reset_slew: assert property ($fell(rst) |-> slew_r == ({NUM_PORTS{SLEW_RST}} & PIN_MASK)
                                 && drive_r == '0 && pull_r == '0)
    else $error("pin control reset values wrong");
  a_missing_pins: assert property ((~pad_oe_n & ~PIN_MASK) == '0)
    else $error("unbonded pin driven");
  a_adc_wins: assert property (adc_claim[8] && dig_claim[8] && dig_oe[8]
                               |=> pad_oe_n[8] && analog_sel[8])
    else $error("converter lost pin to digital peripheral");
  a_dig_direction: assert property (dig_claim[32] && !adc_claim[32] && dig_oe[32]
                                    |=> !pad_oe_n[32] && pad_out[32] == $past(dig_out[32]))
    else $error("peripheral did not own pin e0");
  a_gpio_output: assert property (wr_stb && addr == {PORT_A, REG_DIR} && wdata == 8'hFF
                                  && !dig_claim[0] ##1 !(wr_stb && addr[5:3] == PORT_A)
                                  |=> !pad_oe_n[0] && pad_out[0] == data_r[0])
    else $error("port a pin 0 not driving its data bit");
  a_slew_input: assert property (pad_oe_n[0] |-> !pad_slew[0])
    else $error("slew active on an input");
  a_read_latency: assert property (rd_stb && addr == {PORT_A, REG_SLEW}
                                   |=> rdata == $past(slew_r[7:0]))
    else $error("slew read wrong");
  a_read_once: assert property (!rd_stb |=> rdata == READ_ZERO)
    else $error("read data outlived its cycle");

  // port a has no sharing, so its direction bits alone steer the pads
  a_gpio_dir: assert property (
    1'b1 |=> pad_oe_n[7:0] == ~$past(dir_r[7:0]))
    else $error("port a direction not followed");

  // port a output level is the data bit, zero where not driving
  a_gpio_level: assert property (
    1'b1 |=> pad_out[7:0] == ($past(data_r[7:0]) & $past(dir_r[7:0])))
    else $error("port a output level wrong");

  // the missing eighth bits (bit 7) of c and g stay quiet
  a_unbonded_idle: assert property (
    pad_oe_n[23] && pad_oe_n[55] && !pad_out[23] && !pad_out[55])
    else $error("unbonded pin not idle");

  // converter only ever takes port b and port d pins
  a_adc_ports_only: assert property (
    (analog_sel & ~ADC_MASK) == '0)
    else $error("converter took a pin outside b and d");

  // a pin handed to the converter is never driven
  a_adc_undriven: assert property (
    (analog_sel & ~pad_oe_n) == '0)
    else $error("converter pin driven");

  // a converter pin never sees the pullup
  a_adc_no_pullup: assert property (
    (analog_sel & pad_pullup) == '0)
    else $error("pullup on converter pin");

  // port a is never handed to the converter
  a_port_a_plain: assert property (
    analog_sel[7:0] == 8'h00)
    else $error("port a pin claimed");

  // high drive only on a driven pin
  a_drive_inputs: assert property (
    (pad_drive_hi & pad_oe_n) == '0)
    else $error("high drive on an input");

  // slew limiting only on a driven pin, all pins
  a_slew_inputs_all: assert property (
    (pad_slew & pad_oe_n) == '0)
    else $error("slew on an input pin");

  // on driven pins the slew pad follows its slew bit
  a_slew_follow: assert property (
    1'b1 |=> (pad_slew & ~pad_oe_n) == ($past(slew_r) & ~pad_oe_n))
    else $error("slew pad does not follow slew bit");

  // on driven pins the drive pad follows its drive bit
  a_drive_follow: assert property (
    1'b1 |=> (pad_drive_hi & ~pad_oe_n) == ($past(drive_r) & ~pad_oe_n))
    else $error("drive pad does not follow drive bit");

  // undriven pins show a low level
  a_idle_low: assert property (
    (pad_out & pad_oe_n) == '0)
    else $error("level on undriven pin");

  // a data write lands in the next cycle
  a_data_write: assert property (
    wr_stb && addr == {PORT_A, REG_DATA} |=> data_r[7:0] == $past(wdata))
    else $error("data write lost");

  // a direction write lands in the next cycle
  a_dir_write: assert property (
    wr_stb && addr == {PORT_A, REG_DIR} |=> dir_r[7:0] == $past(wdata))
    else $error("direction write lost");

  // a pullup write lands in the next cycle
  a_pull_write: assert property (
    wr_stb && addr == {PORT_A, REG_PULL} |=> pull_r[7:0] == $past(wdata))
    else $error("pullup write lost");

  // a slew write lands bit for bit
  a_slew_write: assert property (
    wr_stb && addr == {PORT_A, REG_SLEW} |=> slew_r[7:0] == $past(wdata))
    else $error("slew write lost");

  // drive register reads back one cycle after the strobe
  a_drive_read: assert property (
    rd_stb && addr == {PORT_A, REG_DRIVE} |=> rdata == $past(drive_r[7:0]))
    else $error("drive read wrong");

  // async serial pin on port e driven by its peripheral
  a_e_serial_out: assert property (
    dig_claim[33] && !adc_claim[33] && dig_oe[33]
    |=> !pad_oe_n[33] && pad_out[33] == $past(dig_out[33]))
    else $error("port e serial pin not owned");

  // keyboard input on port d leaves the pin undriven
  a_d_key_input: assert property (
    dig_claim[31] && !adc_claim[31] && !dig_oe[31] |=> pad_oe_n[31])
    else $error("keyboard input pin driven");

  // port b top bit goes to converter channel seven
  a_b_channel: assert property (
    adc_claim[15] |=> analog_sel[15])
    else $error("converter channel not handed over");

  // direction bits all clear as reset ends
  a_dir_reset_hold: assert property (
    $fell(rst) |-> dir_r == '0)
    else $error("direction bits not cleared");

  c_adc_claim:   cover property (analog_sel[8]);
  c_dig_out:     cover property (!pad_oe_n[32] && dig_claim[32]);
  c_gpio_drive:  cover property (!pad_oe_n[0] && pad_slew[0] && pad_drive_hi[0]);
  c_read_input:  cover property (rd_stb ##1 rdata != READ_ZERO);

endmodule

// ### pio_board.sv
// board model: drives pad levels back into the port block
// assumes the bench supplies the board drive; undriven pads without pullup wander
`timescale 1ns/1ps

module pio_board
  import pio_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [FLAT_W-1:0] pad_out,
  input  wire logic [FLAT_W-1:0] pad_oe_n,
  input  wire logic [FLAT_W-1:0] pad_pullup,
  input  wire logic [FLAT_W-1:0] board_en,
  input  wire logic [FLAT_W-1:0] board_val,
  output logic      [FLAT_W-1:0] pad_in
);
  logic [FLAT_W-1:0] wander_r = '0;

  // floating pads change every cycle so a stale level is never trusted
  always @(posedge mclk) begin
    wander_r <= ~wander_r;
  end

  // pad level: chip drive, then board drive, then pullup, else floating
  always_comb begin
    for (int i = 0; i < FLAT_W; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (board_en[i]) pad_in[i] = board_val[i];
      else if (pad_pullup[i]) pad_in[i] = 1'b1;
      else pad_in[i] = wander_r[i];
    end
  end
endmodule

// ### pio_ports_test.sv
// testbench for the parallel i/o ports: register access, pads, peripheral claims
// assumes pio_board closes the pad loop; peripherals are driven by the bench
`timescale 1ns/1ps

module pio_ports_test
  import pio_pkg::*;
;
  logic              mclk = 0, rst = 1, wr_stb = 0, rd_stb = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = '0, rdata, rv;
  logic [FLAT_W-1:0] pad_in, pad_out, pad_oe_n, pad_pullup, pad_slew, pad_drive_hi;
  logic [FLAT_W-1:0] analog_sel, adc_claim = '0, dig_claim = '0, dig_oe = '0, dig_out = '0;
  logic [FLAT_W-1:0] board_en = '0, board_val = '0;
  int                failures = 0, checks_done = 0, cycles = 0;

  always #2 mclk = ~mclk;

  pio_ports i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .pad_slew(pad_slew), .pad_drive_hi(pad_drive_hi),
    .analog_sel(analog_sel), .adc_claim(adc_claim), .dig_claim(dig_claim),
    .dig_oe(dig_oe), .dig_out(dig_out));
  pio_board i_board (.mclk(mclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .board_en(board_en), .board_val(board_val), .pad_in(pad_in));

  task automatic chk(input string what, input logic [FLAT_W-1:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // cycle ceiling against hangs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    settle();
    // reset state of every port's direction, pullup, slew and drive registers, then pad enables and converter selects
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd(6'(p * 8 + 1), rv); chk("dir reset", 56'(DIR_RESET), 56'(rv));
      rd(6'(p * 8 + 2), rv); chk("pull reset", 56'(PULL_RESET), 56'(rv));
      rd(6'(p * 8 + 3), rv); chk("slew reset", 56'(SLEW_RESET & PIN_MASK[p*8+:8]), 56'(rv));
      rd(6'(p * 8 + 4), rv); chk("drive reset", 56'(DRIVE_RESET), 56'(rv));
    end
    chk("oe reset", {FLAT_W{1'b1}}, pad_oe_n);
    chk("analog reset", '0, analog_sel);
    rd(6'h38, rv); chk("unmapped read", 56'(READ_ZERO), 56'(rv));
    $display("test reset done");
    // port a output with slew and drive, then half inputs
    wr(6'h00, 8'h5A); wr(6'h01, 8'hFF); wr(6'h03, 8'h0F); wr(6'h04, 8'hF0);
    settle();
    chk("a oe", 56'h0, 56'(pad_oe_n[7:0]));
    chk("a out", 56'h5A, 56'(pad_out[7:0]));
    chk("a slew", 56'h0F, 56'(pad_slew[7:0]));
    chk("a drive", 56'hF0, 56'(pad_drive_hi[7:0]));
    rd(6'h04, rv); chk("a drive rd", 56'hF0, 56'(rv));
    wr(6'h01, 8'h0F); wr(6'h03, 8'hFF);
    settle();
    chk("a slew in", 56'h0F, 56'(pad_slew[7:0]));
    chk("a drive in", 56'h00, 56'(pad_drive_hi[7:0]));
    wr(6'h03, 8'h00);
    settle();
    chk("a slew off", 56'h00, 56'(pad_slew[7:0]));
    $display("test port a output done");
    // inputs: board level and pullups
    wr(6'h01, 8'h00);
    @(posedge mclk);
    board_en[7:0] <= 8'hFF; board_val[7:0] <= 8'hC3;
    settle();
    rd(6'h00, rv); chk("a pins", 56'hC3, 56'(rv));
    @(posedge mclk);
    board_en[7:0] <= 8'h00; wr(6'h02, 8'hFF);
    settle();
    chk("a pullup", 56'hFF, 56'(pad_pullup[7:0]));
    rd(6'h05, rv); chk("a pulled", 56'hFF, 56'(rv));
    wr(6'h11, 8'hFF); rd(6'h11, rv); chk("c dir", 56'h7F, 56'(rv));
    settle();
    chk("c7 oe", 56'h1, 56'(pad_oe_n[23]));
    $display("test inputs done");
    // peripheral claims: digital on e0, converter over digital on d0, converter alone on b0, none taken on port a
    @(posedge mclk);
    dig_claim[32] <= 1'b1; dig_oe[32] <= 1'b1; dig_out[32] <= 1'b1;
    dig_claim[24] <= 1'b1; dig_oe[24] <= 1'b1; adc_claim[24] <= 1'b1;
    adc_claim[8] <= 1'b1; adc_claim[0] <= 1'b1; dig_claim[1] <= 1'b1; dig_oe[1] <= 1'b1;
    settle();
    chk("e0 oe", 56'h0, 56'(pad_oe_n[32]));
    chk("e0 out", 56'h1, 56'(pad_out[32]));
    chk("d0 analog", 56'h1, 56'(analog_sel[24]));
    chk("d0 oe", 56'h1, 56'(pad_oe_n[24]));
    chk("b0 analog", 56'h1, 56'(analog_sel[8]));
    chk("a0 analog", 56'h0, 56'(analog_sel[0]));
    chk("a1 oe", 56'h1, 56'(pad_oe_n[1]));
    $display("test claims done");
    stop_test();
  end
endmodule
